/* File: hdl/cbo_ctrl.sv */
// Purpose: Output gating, power sequencing, strap latching and SMBus slave
// Assumes: ref_clk_in and strap levels are synchronous to clk; pins are not
// Notes: Output pairs are sampled copies of the input clock, gated while low
`timescale 1ns/1ps
`default_nettype none
module cbo_ctrl
	import cbo_pkg::*;
#(
	parameter int N_OUT = CBO_NOUT,
	parameter int LOCK_CYC = CBO_LOCK_CYC,
	parameter int WAKE_CYC = CBO_WAKE_CYC,
	parameter int STRETCH_CYC = CBO_STRETCH_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ref_clk_in,
	input wire logic [CBO_NOUT-1:0] oe_n_pins,
	input wire logic power_good_input,
	input wire logic freq_select_strap,
	input wire logic address_select_strap,
	input wire logic bw_strap_lo,
	input wire logic bw_strap_hi,
	input wire cbo_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire logic smb_scl_i,
	input wire logic smb_sda_i,
	output logic smb_sda_o,
	output logic smb_sda_oe,
	output logic [CBO_NOUT-1:0] clock_output_pair_p,
	output logic [CBO_NOUT-1:0] clock_output_pair_n,
	output logic feedback_output_pair_p,
	output logic feedback_output_pair_n,
	output logic pll_on,
	output logic [1:0] pll_mode,
	output logic freq_sel,
	output logic addr_sel
);
	localparam logic [CBO_TMR_W-1:0] LOCK_LIM = CBO_TMR_W'(LOCK_CYC - 1);
	localparam logic [CBO_TMR_W-1:0] WAKE_LIM = CBO_TMR_W'(WAKE_CYC - 1);
	localparam logic [CBO_TMR_W-1:0] STRETCH_LIM = CBO_TMR_W'(STRETCH_CYC - 1);

	initial begin
		if (N_OUT != CBO_NOUT)
			$error("N_OUT must equal the packaged output count");
		if (LOCK_CYC < 2 || LOCK_CYC >= (1 << CBO_TMR_W))
			$error("LOCK_CYC out of timer range");
		if (WAKE_CYC < 2 || WAKE_CYC >= (1 << CBO_TMR_W))
			$error("WAKE_CYC out of timer range");
		if (STRETCH_CYC < 2 || STRETCH_CYC >= (1 << CBO_TMR_W))
			$error("STRETCH_CYC out of timer range");
	end

	cbo_state_t s;
	cbo_state_t n;
	logic [CBO_NOUT-1:0] req_v;
	logic [1:0] bw_dec;
	logic [7:0] smb_rv;
	logic ref_rise;
	logic srise;
	logic sfall;
	logic sstart;
	logic sstop;
	logic smb_we;

	function automatic logic [7:0] cbo_rd(input logic [7:0] a, input cbo_state_t st);
		if (a == CBO_REG_CTRL0)
			return {st.bw_code, 2'h0, st.swpll, st.freq_sel};
		else if (a == CBO_REG_OE)
			return st.oe_reg;
		else
			return 8'h00;
	endfunction

	// Pin and software enables combine; pin is low active
	assign req_v = s.oe_reg & ~s.oe_s2;
	// Neither comparator tripped means the middle level
	assign bw_dec = bw_strap_lo ? CBO_PLL_LOW_BANDWIDTH :
		(bw_strap_hi ? CBO_PLL_HIGH_BANDWIDTH : CBO_PLL_BYPASS);
	assign smb_rv = cbo_rd(s.cmd, s);
	assign ref_rise = ref_clk_in & ~s.ref_q;
	assign srise = s.scl_s2 & ~s.scl_q;
	assign sfall = ~s.scl_s2 & s.scl_q;
	assign sstart = s.scl_s2 & s.scl_q & s.sda_q & ~s.sda_s2;
	assign sstop = s.scl_s2 & s.scl_q & ~s.sda_q & s.sda_s2;

	always_comb begin
		n = s;
		smb_we = 1'b0;
		// Asynchronous pins pass two flops before use
		n.oe_s1 = oe_n_pins;
		n.oe_s2 = s.oe_s1;
		n.pg_s1 = power_good_input;
		n.pg_s2 = s.pg_s1;
		// Oversampled by clk, so standard and fast mode rates both fit
		n.scl_s1 = smb_scl_i;
		n.scl_s2 = s.scl_s1;
		n.scl_q = s.scl_s2;
		n.sda_s1 = smb_sda_i;
		n.sda_s2 = s.sda_s1;
		n.sda_q = s.sda_s2;
		n.ref_q = ref_clk_in;

		case (s.pwr)
			CBO_PW_OFF: begin
				if (s.pg_s2) begin
					n.freq_sel = freq_select_strap;
					n.sa = address_select_strap;
					n.bw_code = bw_dec;
					n.pll_mode = s.swpll[CBO_SWPLL_OVR] ? s.swpll[1:0] : bw_dec;
					n.pll_on = 1'b1;
					n.fb_en = 1'b1;
					n.tmr = '0;
					n.pwr = CBO_PW_LOCK;
				end
			end
			CBO_PW_LOCK, CBO_PW_WAKE: begin
				if (!s.pg_s2) begin
					n.pdcnt = 2'h0;
					n.pwr = CBO_PW_STOP;
				end else if (s.tmr != ((s.pwr == CBO_PW_LOCK) ? LOCK_LIM : WAKE_LIM)) begin
					n.tmr = s.tmr + CBO_TMR_W'(1);
				end else if (!ref_clk_in) begin
					// Open the gate only while the clock is low
					n.gate = 1'b1;
					n.pwr = CBO_PW_RUN;
				end
			end
			CBO_PW_RUN: begin
				if (!s.pg_s2) begin
					n.pdcnt = 2'h0;
					n.pwr = CBO_PW_STOP;
				end
			end
			CBO_PW_STOP: begin
				if (s.pg_s2) begin
					if (s.gate) begin
						n.pwr = CBO_PW_RUN;
					end else begin
						n.tmr = '0;
						n.pwr = CBO_PW_WAKE;
					end
				end else if (s.pdcnt == CBO_PD_EDGES && !ref_clk_in) begin
					// Clocks stop here; the VCO follows one cycle later
					n.gate = 1'b0;
					n.fb_en = 1'b0;
					n.pwr = CBO_PW_DOWN;
				end else if (ref_rise && s.pdcnt != CBO_PD_EDGES) begin
					n.pdcnt = s.pdcnt + 2'h1;
				end
			end
			CBO_PW_DOWN: begin
				n.pll_on = 1'b0;
				if (s.pg_s2) begin
					// A power cycle is the warm reset that applies the override
					n.pll_mode = s.swpll[CBO_SWPLL_OVR] ? s.swpll[1:0] : s.bw_code;
					n.pll_on = 1'b1;
					n.fb_en = 1'b1;
					n.tmr = '0;
					n.pwr = CBO_PW_WAKE;
				end
			end
			default: begin
				n.pwr = CBO_PW_OFF;
			end
		endcase

		// Each pair changes state only while the clock is low, so no runt pulse
		for (int i = 0; i < CBO_NOUT; i++) begin
			if (req_v[i] == s.run[i]) begin
				n.ecnt[i] = 4'h0;
			end else begin
				if (ref_rise && s.ecnt[i] != 4'hf)
					n.ecnt[i] = s.ecnt[i] + 4'h1;
				if (s.ecnt[i] >= CBO_OE_EDGES && !ref_clk_in) begin
					n.run[i] = req_v[i];
					n.ecnt[i] = 4'h0;
				end
			end
		end

		// SMBus slave; it never touches SCL, so it cannot stretch the clock
		if (s.pwr == CBO_PW_DOWN) begin
			n.sst = CBO_SM_IDLE;
			n.sda_oe = 1'b0;
		end else if (sstart) begin
			n.sst = CBO_SM_RX;
			n.bitc = 3'h0;
			n.bidx = 2'h0;
			n.bdone = 1'b0;
			n.sda_oe = 1'b0;
		end else if (sstop) begin
			n.sst = CBO_SM_IDLE;
			n.sda_oe = 1'b0;
		end else begin
			case (s.sst)
				CBO_SM_RX: begin
					if (srise) begin
						n.sh = {s.sh[6:0], s.sda_s2};
						n.bitc = s.bitc + 3'h1;
						if (s.bitc == 3'h7)
							n.bdone = 1'b1;
					end else if (sfall && s.bdone) begin
						n.bdone = 1'b0;
						n.bitc = 3'h0;
						if (s.bidx != 2'h3)
							n.bidx = s.bidx + 2'h1;
						if (s.bidx == 2'h0) begin
							if (s.sh[7:1] == CBO_SMB_ADDR) begin
								n.rw = s.sh[0];
								n.sda_oe = 1'b1;
								n.sst = CBO_SM_ACK;
							end else begin
								n.sst = CBO_SM_IDLE;
							end
						end else if (s.bidx == 2'h1) begin
							n.cmd = s.sh;
							n.sda_oe = 1'b1;
							n.sst = CBO_SM_ACK;
						end else begin
							smb_we = 1'b1;
							n.sda_oe = 1'b1;
							n.sst = CBO_SM_ACK;
						end
					end
				end
				CBO_SM_ACK: begin
					if (sfall) begin
						n.bitc = 3'h0;
						if (s.rw) begin
							n.sh = smb_rv;
							n.sda_oe = ~smb_rv[7];
							n.sst = CBO_SM_TX;
						end else begin
							n.sda_oe = 1'b0;
							n.sst = CBO_SM_RX;
						end
					end
				end
				CBO_SM_TX: begin
					if (sfall) begin
						if (s.bitc == 3'h7) begin
							n.sda_oe = 1'b0;
							n.sst = CBO_SM_MACK;
						end else begin
							n.sh = {s.sh[6:0], 1'b0};
							n.sda_oe = ~s.sh[6];
							n.bitc = s.bitc + 3'h1;
						end
					end
				end
				CBO_SM_MACK: begin
					if (srise && s.sda_s2) begin
						n.sst = CBO_SM_IDLE;
					end else if (sfall) begin
						n.sh = smb_rv;
						n.sda_oe = ~smb_rv[7];
						n.bitc = 3'h0;
						n.sst = CBO_SM_TX;
					end
				end
				default: begin
					n.sda_oe = 1'b0;
				end
			endcase
		end

		// Watchdog on our own pull-down of SDA
		if (s.sda_oe)
			n.stmr = s.stmr + CBO_TMR_W'(1);
		else
			n.stmr = '0;
		if (s.sda_oe && s.stmr == STRETCH_LIM) begin
			n.sda_oe = 1'b0;
			n.sst = CBO_SM_IDLE;
			n.stmr = '0;
		end

		// Register port wins over a same-cycle SMBus write
		if (bus_req.wr) begin
			if (bus_req.addr == CBO_REG_CTRL0)
				n.swpll = bus_req.wdata[CBO_SWPLL_LSB+2:CBO_SWPLL_LSB];
			else if (bus_req.addr == CBO_REG_OE)
				n.oe_reg = bus_req.wdata;
		end else if (smb_we) begin
			if (s.cmd == CBO_REG_CTRL0)
				n.swpll = s.sh[CBO_SWPLL_LSB+2:CBO_SWPLL_LSB];
			else if (s.cmd == CBO_REG_OE)
				n.oe_reg = s.sh;
		end
		n.rdata = bus_req.rd ? cbo_rd(bus_req.addr, s) : 8'h00;

		n.clk_p = {CBO_NOUT{n.ref_q & n.gate}} & n.run;
		n.clk_n = {CBO_NOUT{~n.ref_q & n.gate}} & n.run;
		n.fb_p = n.ref_q & n.fb_en;
		n.fb_n = ~n.ref_q & n.fb_en;
		n.sda_o = 1'b0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.oe_reg <= CBO_OE_RESET;
			s.swpll <= CBO_SWPLL_RESET;
			s.pwr <= CBO_PW_OFF;
			s.sst <= CBO_SM_IDLE;
			// Idle bus level, so no false SCL or SDA edge after reset
			s.scl_s1 <= 1'b1;
			s.scl_s2 <= 1'b1;
			s.scl_q <= 1'b1;
			s.sda_s1 <= 1'b1;
			s.sda_s2 <= 1'b1;
			s.sda_q <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign bus_rdata = s.rdata;
	assign smb_sda_o = s.sda_o;
	assign smb_sda_oe = s.sda_oe;
	assign clock_output_pair_p = s.clk_p;
	assign clock_output_pair_n = s.clk_n;
	assign feedback_output_pair_p = s.fb_p;
	assign feedback_output_pair_n = s.fb_n;
	assign pll_on = s.pll_on;
	assign pll_mode = s.pll_mode;
	assign freq_sel = s.freq_sel;
	assign addr_sel = s.sa;

	a_enable_pair: assert property (@(posedge clk) disable iff (!rstn)
		$rose(s.run[0]) |-> $past(s.oe_reg[0]) && !$past(s.oe_s2[0]))
		else $error("pair 0 started without both enables");
	a_oe_reset: assert property (@(posedge clk)
		$rose(rstn) |-> s.oe_reg == CBO_OE_RESET)
		else $error("enable bits not set after reset");
	a_disabled_low: assert property (@(posedge clk) disable iff (!rstn)
		((s.clk_p | s.clk_n) & ~s.run) == '0)
		else $error("disabled pair not low/low");
	a_down_all_low: assert property (@(posedge clk) disable iff (!rstn)
		(s.pwr == CBO_PW_DOWN) |-> (s.clk_p | s.clk_n) == '0 && !s.fb_p && !s.fb_n)
		else $error("outputs running in power-down");
	a_stop_min4: assert property (@(posedge clk) disable iff (!rstn)
		$fell(s.run[0]) |-> $past(s.ecnt[0]) >= CBO_OE_EDGES)
		else $error("pair 0 stopped before four clocks");
	a_vco_last: assert property (@(posedge clk) disable iff (!rstn)
		$fell(s.pll_on) |-> !$past(s.gate) && !$past(s.fb_en))
		else $error("VCO off while clocks still enabled");
	a_lock_bound: assert property (@(posedge clk) disable iff (!rstn)
		(s.pwr == CBO_PW_LOCK) |-> s.tmr <= LOCK_LIM)
		else $error("lock wait overran");
	a_strap_hold: assert property (@(posedge clk) disable iff (!rstn)
		(s.pwr != CBO_PW_OFF) |=> $stable(s.bw_code))
		else $error("latched strap changed");
	a_rd_strap: assert property (@(posedge clk) disable iff (!rstn)
		(bus_req.rd && bus_req.addr == CBO_REG_CTRL0) |=> bus_rdata[7:6] == $past(s.bw_code))
		else $error("readback bits differ from strap");
	a_sda_bound: assert property (@(posedge clk) disable iff (!rstn)
		s.sda_oe |-> s.stmr <= STRETCH_LIM)
		else $error("SDA held beyond limit");
	a_down_float: assert property (@(posedge clk) disable iff (!rstn)
		(s.pwr == CBO_PW_DOWN) |=> !s.sda_oe)
		else $error("SDA driven in power-down");
	a_foreign_nack: assert property (@(posedge clk) disable iff (!rstn)
		(s.sst == CBO_SM_RX && sfall && s.bdone && s.bidx == 2'h0 &&
		s.sh[7:1] != CBO_SMB_ADDR) |=> !s.sda_oe)
		else $error("foreign address acknowledged");
	a_oe_latency: assert property (@(posedge clk) disable iff (!rstn)
		(req_v[0] != s.run[0]) |-> s.ecnt[0] < CBO_OE_MAX_EDGES)
		else $error("pair 0 switch later than twelve periods");
	a_pd_two_edges: assert property (@(posedge clk) disable iff (!rstn)
		$fell(s.gate) |-> $past(s.pdcnt) == CBO_PD_EDGES)
		else $error("outputs stopped before two low samples");
	a_wake_mode: assert property (@(posedge clk) disable iff (!rstn)
		(s.pwr == CBO_PW_DOWN && s.pg_s2 && s.swpll[CBO_SWPLL_OVR]) |=>
		s.pll_mode == $past(s.swpll[1:0]))
		else $error("override mode not applied on wake");
endmodule
`default_nettype wire

/* File: hdl/cbo_pkg.sv */
// Purpose: Shared constants and types of the clock buffer output control block
// Assumes: 125 MHz system clock, eight output pairs, byte wide register port
// Notes: Long counts are overridable as parameters of the top module
// How it works
// - Pair runs only when its software bit is 1 and its pin is low
// - Enable pins are active low and may change at any instant
// - Software enable bits are active high and reset to enabled
// - A disabled pair drives both lines low
// - Power pin low parks every pair and feedback low, PLL off
// - Pin falling restarts the pair cleanly within 4 to 12 periods
// - Pin rising gives at least four more clocks, stop within 12
// - Outputs run 1:1 with input; strap 0 means 133.33, 1 means 100.00 MHz
// - Switching between 100 and 133 MHz happens without glitches
// - Power-good rising edge latches frequency and address straps
// - After first power-good the pin acts as active low power-down
// - Two low samples on rising edges stop outputs at next fall, VCO last
// - Locked stable clocks within 1.8 ms of power-good
// - Parked outputs run again within 300 us of power-down release
// - Bandwidth strap low, middle, high gives low bandwidth, bypass, high
// - Control byte 0 bits 7:6 read strap as 00, 01 or 11
// - Bits 2:1 override PLL mode only with bit 3 set, after warm reset
// - Bits 7:6 keep the latched strap whatever software writes
// - SMBus slave answers at seven-bit address 1101100
// - SMBus runs at 100 kbps, 400 kbps optional
// - SMBus lines never held low over 10 ms, no clock stretching
// - In power-down SMBus pins float and registers keep their values
package cbo_pkg;
	localparam int CBO_NOUT = 8;
	localparam int CBO_CLK_NS = 8;
	localparam int CBO_LOCK_NS = 1800000;
	localparam int CBO_LOCK_CYC = CBO_LOCK_NS / CBO_CLK_NS;
	localparam int CBO_WAKE_NS = 300000;
	localparam int CBO_WAKE_CYC = CBO_WAKE_NS / CBO_CLK_NS;
	localparam int CBO_STRETCH_NS = 10000000;
	localparam int CBO_STRETCH_CYC = CBO_STRETCH_NS / CBO_CLK_NS;
	localparam int CBO_TMR_W = 21;
	localparam logic [3:0] CBO_OE_EDGES = 4'h4;
	localparam logic [3:0] CBO_OE_MAX_EDGES = 4'hc;
	localparam logic [1:0] CBO_PD_EDGES = 2'h2;
	localparam logic [7:0] CBO_REG_CTRL0 = 8'h00;
	localparam logic [7:0] CBO_REG_OE = 8'h01;
	localparam logic [7:0] CBO_OE_RESET = 8'hff;
	localparam logic [2:0] CBO_SWPLL_RESET = 3'h3;
	localparam int CBO_SWPLL_LSB = 1;
	localparam int CBO_SWPLL_OVR = 2;
	localparam logic [6:0] CBO_SMB_ADDR = 7'h6c;
	localparam logic [1:0] CBO_PLL_LOW_BANDWIDTH = 2'h0;
	localparam logic [1:0] CBO_PLL_BYPASS = 2'h1;
	localparam logic [1:0] CBO_PLL_HIGH_BANDWIDTH = 2'h3;

	typedef enum logic [2:0] {
		CBO_PW_OFF = 3'h0,
		CBO_PW_LOCK = 3'h1,
		CBO_PW_RUN = 3'h2,
		CBO_PW_STOP = 3'h3,
		CBO_PW_DOWN = 3'h4,
		CBO_PW_WAKE = 3'h5
	} cbo_pwr_t;

	typedef enum logic [2:0] {
		CBO_SM_IDLE = 3'h0,
		CBO_SM_RX = 3'h1,
		CBO_SM_ACK = 3'h2,
		CBO_SM_TX = 3'h3,
		CBO_SM_MACK = 3'h4
	} cbo_smb_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cbo_bus_req_t;

	typedef struct packed {
		logic [CBO_NOUT-1:0] oe_s1;
		logic [CBO_NOUT-1:0] oe_s2;
		logic pg_s1;
		logic pg_s2;
		logic scl_s1;
		logic scl_s2;
		logic scl_q;
		logic sda_s1;
		logic sda_s2;
		logic sda_q;
		logic ref_q;
		cbo_pwr_t pwr;
		logic [CBO_TMR_W-1:0] tmr;
		logic [1:0] pdcnt;
		logic gate;
		logic fb_en;
		logic pll_on;
		logic freq_sel;
		logic sa;
		logic [1:0] bw_code;
		logic [1:0] pll_mode;
		logic [2:0] swpll;
		logic [7:0] oe_reg;
		logic [CBO_NOUT-1:0] run;
		logic [CBO_NOUT-1:0][3:0] ecnt;
		logic [CBO_NOUT-1:0] clk_p;
		logic [CBO_NOUT-1:0] clk_n;
		logic fb_p;
		logic fb_n;
		logic [7:0] rdata;
		cbo_smb_t sst;
		logic [2:0] bitc;
		logic [7:0] sh;
		logic [7:0] cmd;
		logic [1:0] bidx;
		logic rw;
		logic bdone;
		logic sda_oe;
		logic sda_o;
		logic [CBO_TMR_W-1:0] stmr;
	} cbo_state_t;
endpackage

/* File: test/cbo_host_model.sv */
// Purpose: Upstream reference clock source and SMBus line pull-up
// Assumes: Reference clock derived from clk, slower than clk
// Notes: Clock parks low while stopped instead of free running
`timescale 1ns/1ps
`default_nettype none
module cbo_host_model #(
	parameter int HALF = 2
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic sda_host,
	input wire logic sda_oe_dev,
	output logic ref_clk,
	output logic sda_line
);
	int cnt;
	// Stopped by the bench only after power-down has been asserted
	always @(posedge clk or negedge rstn) begin
		if (!rstn || !run) begin
			ref_clk <= 1'b0;
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			ref_clk <= ~ref_clk;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// Open drain line with external pull-up
	assign sda_line = sda_host & ~sda_oe_dev;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench of the clock buffer output control block
// Assumes: Shortened lock, wake and stretch counts
// Notes: Outputs sampled on falling clk, inputs changed after rising clk
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
	import cbo_pkg::*;
	localparam int LOCK = 20;
	localparam int WAKE = 10;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] oe_n = 8'h00;
	logic pg = 1'b0;
	logic fsel = 1'b0;
	logic asel = 1'b0;
	logic bw_lo = 1'b0;
	logic bw_hi = 1'b0;
	logic scl = 1'b1;
	logic sda_h = 1'b1;
	logic ref_run = 1'b1;
	cbo_bus_req_t req = '0;
	logic [7:0] rdata;
	logic [7:0] cp;
	logic [7:0] cn;
	logic [1:0] pll_mode;
	logic sda_line, sda_o, sda_oe, ref_clk, fb_p, fb_n, pll_on, fs_q, sa_q;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	cbo_host_model u_cbo_host_model (.clk(clk), .rstn(rstn), .run(ref_run),
		.sda_host(sda_h), .sda_oe_dev(sda_oe), .ref_clk(ref_clk), .sda_line(sda_line));
	cbo_ctrl #(.LOCK_CYC(LOCK), .WAKE_CYC(WAKE), .STRETCH_CYC(200)) u_cbo_ctrl (
		.clk(clk), .rstn(rstn), .ref_clk_in(ref_clk), .oe_n_pins(oe_n),
		.power_good_input(pg), .freq_select_strap(fsel), .address_select_strap(asel),
		.bw_strap_lo(bw_lo), .bw_strap_hi(bw_hi), .bus_req(req), .bus_rdata(rdata),
		.smb_scl_i(scl), .smb_sda_i(sda_line), .smb_sda_o(sda_o), .smb_sda_oe(sda_oe),
		.clock_output_pair_p(cp), .clock_output_pair_n(cn),
		.feedback_output_pair_p(fb_p), .feedback_output_pair_n(fb_n),
		.pll_on(pll_on), .pll_mode(pll_mode), .freq_sel(fs_q), .addr_sel(sa_q));

	task automatic report_and_stop();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic do_reset();
		@(posedge clk);
		rstn <= 1'b0;
		pg <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		d = rdata;
	endtask

	// Running pair: p toggles, never both high; stopped pair: both low
	task automatic chk_pairs(input logic [7:0] m, input string nm);
		logic [7:0] hi, on, bad;
		hi = '0;
		on = '0;
		bad = '0;
		repeat (16) begin
			@(negedge clk);
			hi |= cp;
			on |= cp | cn;
			bad |= cp & cn;
		end
		`CHK(nm, {m, m, 8'h00}, {hi, on, bad})
	endtask

	// Reference rises seen until pair i reaches the wanted activity
	task automatic lat(input int i, input logic act, output int n);
		logic pr;
		n = 0;
		pr = ref_clk;
		for (int k = 0; k < 200; k++) begin
			@(negedge clk);
			if (ref_clk && !pr) n++;
			pr = ref_clk;
			if ((cp[i] | cn[i]) == act) break;
		end
	endtask

	task automatic s_reset();
		logic [7:0] d;
		do_reset();
		bus_rd(CBO_REG_OE, d);
		`CHK("oe reset", 8'hff, d)
		bus_rd(CBO_REG_CTRL0, d);
		`CHK("ctrl0 mode", 3'h3, d[3:1])
		bus_rd(8'h05, d);
		`CHK("unmapped", 8'h00, d)
		chk_pairs(8'h00, "pg low pairs");
		`CHK("pg low pll", 3'h0, {pll_on, fb_p, fb_n})
	endtask

	task automatic s_straps();
		logic [7:0] d;
		logic [1:0] code [3] = '{2'h0, 2'h1, 2'h3};
		for (int k = 0; k < 3; k++) begin
			do_reset();
			@(posedge clk);
			fsel <= ~k[0];
			asel <= k[0];
			bw_lo <= (k == 0);
			bw_hi <= (k == 2);
			pg <= 1'b1;
			for (int w = 0; w < 20 && pll_on !== 1'b1; w++) @(negedge clk);
			`CHK("mode", code[k], pll_mode)
			`CHK("straps", {~k[0], k[0]}, {fs_q, sa_q})
			bus_rd(CBO_REG_CTRL0, d);
			`CHK("readback", {code[k], ~k[0]}, {d[7:6], d[0]})
		end
		@(posedge clk);
		fsel <= 1'b0;
		repeat (LOCK + 20) @(posedge clk);
		`CHK("freq held", 1'b1, fs_q)
		chk_pairs(8'hff, "all run");
	endtask

	task automatic smb_addr(input logic [7:0] b, input logic ack);
		@(posedge clk);
		sda_h <= 1'b0;
		repeat (20) @(posedge clk);
		scl <= 1'b0;
		for (int k = 7; k >= 0; k--) begin
			repeat (20) @(posedge clk);
			sda_h <= b[k];
			repeat (20) @(posedge clk);
			scl <= 1'b1;
			repeat (20) @(posedge clk);
			scl <= 1'b0;
		end
		repeat (20) @(posedge clk);
		sda_h <= 1'b1;
		repeat (20) @(posedge clk);
		scl <= 1'b1;
		repeat (10) @(negedge clk);
		`CHK("ack", {ack, 1'b0}, {sda_oe, sda_o})
		repeat (10) @(posedge clk);
		scl <= 1'b0;
		repeat (20) @(posedge clk);
		sda_h <= 1'b0;
		repeat (20) @(posedge clk);
		scl <= 1'b1;
		repeat (20) @(posedge clk);
		sda_h <= 1'b1;
		repeat (20) @(negedge clk);
		`CHK("released", 1'b0, sda_oe)
	endtask

	// One SCL period with SCL low at entry and exit; line sampled while SCL high
	task automatic smb_bit(input logic b, output logic seen);
		repeat (20) @(posedge clk);
		sda_h <= b;
		repeat (20) @(posedge clk);
		scl <= 1'b1;
		repeat (10) @(negedge clk);
		seen = sda_line;
		repeat (10) @(posedge clk);
		scl <= 1'b0;
	endtask

	// Eight bits then the acknowledge slot, host releases SDA in that slot
	task automatic smb_xfer(input logic [7:0] b, input logic e, output logic [7:0] got);
		logic s;
		for (int k = 7; k >= 0; k--) begin
			smb_bit(b[k], s);
			got[k] = s;
		end
		smb_bit(1'b1, s);
		`CHK("smb ack", e, s)
	endtask

	task automatic smb_start();
		@(posedge clk);
		sda_h <= 1'b0;
		repeat (20) @(posedge clk);
		scl <= 1'b0;
	endtask

	task automatic smb_stop();
		repeat (20) @(posedge clk);
		sda_h <= 1'b0;
		repeat (20) @(posedge clk);
		scl <= 1'b1;
		repeat (20) @(posedge clk);
		sda_h <= 1'b1;
		repeat (20) @(posedge clk);
	endtask

	task automatic s_smb();
		logic [7:0] d;
		logic [7:0] a;
		logic s;
		a = {CBO_SMB_ADDR, 1'b0};
		smb_start();
		smb_xfer(a, 1'b0, d);
		smb_xfer(CBO_REG_OE, 1'b0, d);
		smb_xfer(8'ha5, 1'b0, d);
		smb_stop();
		bus_rd(CBO_REG_OE, d);
		`CHK("smb write", 8'ha5, d)
		smb_start();
		smb_xfer(a | 8'h01, 1'b0, d);
		smb_xfer(8'hff, 1'b1, d);
		`CHK("smb read", 8'ha5, d)
		smb_stop();
		// SCL held high in the acknowledge until the watchdog lets go
		smb_start();
		for (int k = 7; k >= 0; k--) begin
			smb_bit(a[k], s);
		end
		repeat (20) @(posedge clk);
		sda_h <= 1'b1;
		repeat (20) @(posedge clk);
		scl <= 1'b1;
		repeat (10) @(negedge clk);
		`CHK("sda held", 1'b1, sda_oe)
		repeat (200) @(negedge clk);
		`CHK("sda timeout", 1'b0, sda_oe)
	endtask

	task automatic s_oe();
		int n;
		@(posedge clk);
		oe_n <= 8'h01;
		lat(0, 1'b0, n);
		`CHK("stop lat", 1'b1, n >= 4 && n <= 12)
		@(posedge clk);
		oe_n <= 8'h00;
		lat(0, 1'b1, n);
		`CHK("start lat", 1'b1, n >= 4 && n <= 12)
		bus_wr(CBO_REG_OE, 8'hfd);
		@(posedge clk);
		oe_n <= 8'h04;
		repeat (40) @(posedge clk);
		chk_pairs(8'hf9, "gating");
		@(posedge clk);
		oe_n <= 8'h00;
	endtask

	task automatic s_pd();
		logic [7:0] d;
		bus_wr(CBO_REG_OE, 8'h7f);
		bus_wr(CBO_REG_CTRL0, 8'h08);
		bus_rd(CBO_REG_CTRL0, d);
		`CHK("override rd", 8'hc9, d)
		`CHK("mode kept", 2'h3, pll_mode)
		@(posedge clk);
		pg <= 1'b0;
		for (int w = 0; w < 60 && (cp | cn) !== 8'h00; w++) @(negedge clk);
		`CHK("vco after", 1'b1, pll_on)
		repeat (3) @(negedge clk);
		`CHK("down", 4'h0, {pll_on, fb_p, fb_n, sda_oe})
		@(posedge clk);
		ref_run <= 1'b0;
		bus_rd(CBO_REG_OE, d);
		`CHK("kept", 8'h7f, d)
		@(posedge clk);
		ref_run <= 1'b1;
		pg <= 1'b1;
		repeat (WAKE + 30) @(posedge clk);
		chk_pairs(8'h7f, "wake");
		`CHK("mode new", 2'h0, pll_mode)
	endtask

	initial begin
		s_reset();
		s_straps();
		smb_addr({CBO_SMB_ADDR, 1'b0}, 1'b1);
		smb_addr(8'hb4, 1'b0);
		s_oe();
		s_pd();
		s_smb();
		report_and_stop();
	end
endmodule
`default_nettype wire
